/* File: irq_unit_defs.vh */
// Register offsets, field positions, vectors, reset values and stack depth for the interrupt unit
`ifndef IRQ_UNIT_DEFS_VH
`define IRQ_UNIT_DEFS_VH

// Printed register indices (byte address is four times the index)
`define IDX_CTRL_LOW      8'h0b
`define IDX_CTRL_HIGH     8'h1e
// Added registers: sticky event status and its mask
`define IDX_EVT_STATUS    8'h30
`define IDX_EVT_MASK      8'h31

// Low control register fields
`define LO_MASTER_EN      0
`define LO_CMPA_EN        1
`define LO_CMPB_EN        2
`define LO_TMRA_EN        3
`define LO_CMPA_PEND      4
`define LO_CMPB_PEND      5
`define LO_TMRA_PEND      6
`define LO_WMASK          8'h7f

// High control register fields
`define HI_TMRB_EN        0
`define HI_CONV_EN        1
`define HI_TMRB_PEND      4
`define HI_CONV_PEND      5
`define HI_WMASK          8'h33

// Vectors
`define VEC_CMPA          11'h004
`define VEC_CMPB          11'h008
`define VEC_TMRA          11'h00c
`define VEC_TMRB          11'h010
`define VEC_CONV          11'h014

// Status register events
`define EV_ACK            0
`define EV_WAKE           1
`define EV_STALL          2
`define EV_WIDTH          3

`define RESET_CTRL        8'h00
`define STACK_DEPTH       8

`endif

/* File: irq_priority.v */
// Fixed priority picker: lowest source index wins, with its vector
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_defs.vh"

module irq_priority (
  // Eligible requests, bit 0 highest priority
  input  wire [4:0]  eligible,
  // Choice
  output reg  [4:0]  grant,
  output reg  [10:0] vector
);

  always @* begin
    grant  = 5'h00;
    vector = 11'h000;
    if (eligible[0]) begin
      grant  = 5'h01;
      vector = `VEC_CMPA;
    end else if (eligible[1]) begin
      grant  = 5'h02;
      vector = `VEC_CMPB;
    end else if (eligible[2]) begin
      grant  = 5'h04;
      vector = `VEC_TMRA;
    end else if (eligible[3]) begin
      grant  = 5'h08;
      vector = `VEC_TMRB;
    end else if (eligible[4]) begin
      grant  = 5'h10;
      vector = `VEC_CONV;
    end
  end

endmodule
`default_nettype wire

/* File: five_source_interrupt_unit.v */
// Five-source interrupt unit with its control registers on a Wishbone slave
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_defs.vh"

// Operation
// - Comparator A falling edge sets low bit 4, vector 04h
// - Comparator B falling edge sets low bit 5, vector 08h
// - Timer A overflow sets low bit 6, vector 0Ch
// - Timer B overflow sets high bit 4, vector 10h
// - Conversion done sets high bit 5, vector 14h
// - Taking a request clears its flag and master enable
// - Service pushes only the program counter, then branches
// - Flags still set while master disabled; no acknowledge
// - Full stack withholds acknowledge until a return
// - Any source wakes the halted device
// - Low: bit0 master, bits1-3 source enables, bit7 zero
// - High: bit0 timer B, bit1 conversion, bits 4-5 flags, others zero
// - Priority cmp A, cmp B, timer A, timer B, conversion
// - Interrupt return sets master enable; plain return not
// - Flags stay set until serviced or cleared
module five_source_interrupt_unit #(
  parameter STACK_DEPTH = `STACK_DEPTH
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Event sources
  input  wire        cmpAOut,
  input  wire        cmpBOut,
  input  wire        timerAOverflow,
  input  wire        timerBOverflow,
  input  wire        conversionDone,
  // Core sequencer
  input  wire        slotStrobe,
  input  wire        retPlain,
  input  wire        retFromIrq,
  input  wire        callPush,
  input  wire        halted,
  output reg         irqTake,
  output reg         pushPc,
  output reg  [10:0] irqVector,
  output reg         wakeUp,
  output wire [3:0]  stackPointer,
  output wire        stackFull,
  // Interrupt output
  output wire        irq
);

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg  [7:0] ctrlLow_r;
  reg  [7:0] ctrlHigh_r;
  reg  [7:0] ctrlLow_nxt;
  reg  [7:0] ctrlHigh_nxt;
  reg  [`EV_WIDTH-1:0] evtStatus_r;
  reg  [`EV_WIDTH-1:0] evtMask_r;
  reg  [`EV_WIDTH-1:0] evtStatus_nxt;
  reg  [3:0] stackPtr_r;
  reg        cmpAPrev_r;
  reg        cmpBPrev_r;
  reg        stallSeen_r;

  wire [4:0]  pending;
  wire [4:0]  srcEnable;
  wire [4:0]  eligible;
  wire [4:0]  grant;
  wire [10:0] vector;
  wire        cmpAFall;
  wire        cmpBFall;
  wire        wbReq;
  wire        wbWrite;
  wire        doService;
  wire        anyEnabled;
  wire [7:0]  regIndex;
  wire [7:0]  wrByte;
  wire        wrCtrlLow;
  wire        wrCtrlHigh;
  wire        wrStatus;
  wire        wrMask;
  wire        rdStrobe;
  wire        anyReturn;
  wire        anyPush;
  wire [3:0]  stackPtr_nxt;
  wire [31:0] readWord;

  // --------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------
  // Register hit: one request strobe qualified by one index compare
  function regHit;
    input       req;
    input [7:0] idx;
    input [7:0] target;
    begin
      regHit = req && (idx == target);
    end
  endfunction

  // Read mux; unmapped indices read as zero so software sees no ghosts
  function [31:0] readMux;
    input [7:0]           idx;
    input [7:0]           low;
    input [7:0]           high;
    input [`EV_WIDTH-1:0] status;
    input [`EV_WIDTH-1:0] mask;
    begin
      case (idx)
        `IDX_CTRL_LOW:   readMux = {24'h000000, low & `LO_WMASK};
        `IDX_CTRL_HIGH:  readMux = {24'h000000, high & `HI_WMASK};
        `IDX_EVT_STATUS: readMux = {29'h00000000, status};
        `IDX_EVT_MASK:   readMux = {29'h00000000, mask};
        default:         readMux = 32'h00000000;
      endcase
    end
  endfunction

  // Stack depth step: push and pop in one cycle cancel out, a push
  // at full and a pop at empty leave the pointer where it is
  function [3:0] stackStep;
    input [3:0] ptr;
    input       push;
    input       pop;
    input       full;
    begin
      stackStep = ptr;
      if (push && !pop && !full) begin
        stackStep = ptr + 4'h1;
      end else if (pop && !push && ptr != 4'h0) begin
        stackStep = ptr - 4'h1;
      end
    end
  endfunction

  assign regIndex = wb_adr_i[9:2];
  assign wrByte   = wb_dat_i[7:0];
  assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite  = wbReq & wb_we_i & wb_sel_i[0];
  // Byte lane 0 carries every register; other lanes are ignored
  assign wrCtrlLow  = regHit(wbWrite, regIndex, `IDX_CTRL_LOW);
  assign wrCtrlHigh = regHit(wbWrite, regIndex, `IDX_CTRL_HIGH);
  assign wrStatus   = regHit(wbWrite, regIndex, `IDX_EVT_STATUS);
  assign wrMask     = regHit(wbWrite, regIndex, `IDX_EVT_MASK);
  assign rdStrobe   = wbReq & ~wb_we_i;
  assign readWord   = readMux(regIndex, ctrlLow_r, ctrlHigh_r, evtStatus_r, evtMask_r);

  // --------------------------------------------------------------
  // Source edges and request flags
  // --------------------------------------------------------------
  // Comparators are levels; only a high-then-low pair of samples counts,
  // so a comparator that sits low raises no further requests
  assign cmpAFall = cmpAPrev_r & ~cmpAOut;
  assign cmpBFall = cmpBPrev_r & ~cmpBOut;

  // Flags and enables are packed in priority order, bit 0 first, so
  // the picker needs no knowledge of the register layout
  assign pending = {ctrlHigh_r[`HI_CONV_PEND], ctrlHigh_r[`HI_TMRB_PEND],
                    ctrlLow_r[`LO_TMRA_PEND], ctrlLow_r[`LO_CMPB_PEND],
                    ctrlLow_r[`LO_CMPA_PEND]};
  assign srcEnable = {ctrlHigh_r[`HI_CONV_EN], ctrlHigh_r[`HI_TMRB_EN],
                      ctrlLow_r[`LO_TMRA_EN], ctrlLow_r[`LO_CMPB_EN],
                      ctrlLow_r[`LO_CMPA_EN]};

  // Full compares against the 4-bit pointer; a deeper core stack up to 15 entries needs only a new value
  assign stackFull  = (stackPtr_r == STACK_DEPTH[3:0]);
  assign stackPointer = stackPtr_r;
  assign anyEnabled = ctrlLow_r[`LO_MASTER_EN] & |(pending & srcEnable);
  assign eligible  = (ctrlLow_r[`LO_MASTER_EN] && !stackFull) ?
                     (pending & srcEnable) : 5'h00;
  // Service happens only on the core's instruction slot, never mid-push
  assign doService = slotStrobe & |eligible & ~callPush;
  // A take pushes like a call; a return of either kind pops
  assign anyReturn    = retPlain | retFromIrq;
  assign anyPush      = doService | callPush;
  assign stackPtr_nxt = stackStep(stackPtr_r, anyPush, anyReturn, stackFull);

  // Priority and vector come from one table so they cannot disagree
  irq_priority u_priority (
    .eligible (eligible),
    .grant    (grant),
    .vector   (vector)
  );

  // --------------------------------------------------------------
  // Control register next state
  // --------------------------------------------------------------
  // The order of the ifs is the priority: software write, then return,
  // then service, then hardware events; a later one overrides an earlier
  // one bit by bit, so no event is ever lost to a write in the same cycle
  always @* begin
    ctrlLow_nxt  = ctrlLow_r;
    ctrlHigh_nxt = ctrlHigh_r;
    if (wrCtrlLow) begin
      ctrlLow_nxt = wrByte & `LO_WMASK;
    end
    if (wrCtrlHigh) begin
      ctrlHigh_nxt = wrByte & `HI_WMASK;
    end
    if (retFromIrq) begin
      ctrlLow_nxt[`LO_MASTER_EN] = 1'b1;
    end
    if (doService) begin
      ctrlLow_nxt[`LO_MASTER_EN] = 1'b0;
      if (grant[0]) ctrlLow_nxt[`LO_CMPA_PEND] = 1'b0;
      if (grant[1]) ctrlLow_nxt[`LO_CMPB_PEND] = 1'b0;
      if (grant[2]) ctrlLow_nxt[`LO_TMRA_PEND] = 1'b0;
      if (grant[3]) ctrlHigh_nxt[`HI_TMRB_PEND] = 1'b0;
      if (grant[4]) ctrlHigh_nxt[`HI_CONV_PEND] = 1'b0;
    end
    // Events set last so a same-cycle clear never loses one
    if (cmpAFall) ctrlLow_nxt[`LO_CMPA_PEND] = 1'b1;
    if (cmpBFall) ctrlLow_nxt[`LO_CMPB_PEND] = 1'b1;
    if (timerAOverflow) ctrlLow_nxt[`LO_TMRA_PEND] = 1'b1;
    if (timerBOverflow) ctrlHigh_nxt[`HI_TMRB_PEND] = 1'b1;
    if (conversionDone) ctrlHigh_nxt[`HI_CONV_PEND] = 1'b1;
  end

  // --------------------------------------------------------------
  // Sticky event status, write one to clear
  // --------------------------------------------------------------
  // Clear first and set after, so an event in the clearing cycle stays
  // visible; the stall bit records only the first cycle of a stall
  always @* begin
    evtStatus_nxt = evtStatus_r;
    if (wrStatus) begin
      evtStatus_nxt = evtStatus_r & ~wrByte[`EV_WIDTH-1:0];
    end
    if (doService) evtStatus_nxt[`EV_ACK] = 1'b1;
    if (halted && |pending) evtStatus_nxt[`EV_WAKE] = 1'b1;
    if (anyEnabled && stackFull && !stallSeen_r) evtStatus_nxt[`EV_STALL] = 1'b1;
  end

  // Level output; software keeps it high until it clears the status
  assign irq = |(evtStatus_r & evtMask_r);

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------
  // Software writes and hardware events are merged in the next-state
  // logic above, so each register has exactly one clocked writer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrlLow_r   <= `RESET_CTRL;
      ctrlHigh_r  <= `RESET_CTRL;
      evtStatus_r <= 3'h0;
      evtMask_r   <= 3'h0;
    end else begin
      ctrlLow_r   <= ctrlLow_nxt;
      ctrlHigh_r  <= ctrlHigh_nxt;
      evtStatus_r <= evtStatus_nxt;
      if (wrMask) begin
        evtMask_r <= wrByte[`EV_WIDTH-1:0];
      end
    end
  end

  // --------------------------------------------------------------
  // Edge history
  // --------------------------------------------------------------
  // Comparator history resets low; the idle comparator level is high,
  // so leaving reset can never look like a falling edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmpAPrev_r  <= 1'b0;
      cmpBPrev_r  <= 1'b0;
      stallSeen_r <= 1'b0;
    end else begin
      cmpAPrev_r  <= cmpAOut;
      cmpBPrev_r  <= cmpBOut;
      stallSeen_r <= anyEnabled & stackFull;
    end
  end

  // --------------------------------------------------------------
  // Service outputs to the core
  // --------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqTake   <= 1'b0;
      pushPc    <= 1'b0;
      irqVector <= 11'h000;
      wakeUp    <= 1'b0;
    end else begin
      // Only the program counter goes on the stack; no status copy
      irqTake   <= doService;
      pushPc    <= doService;
      // The vector holds after the pulse so the core may fetch late
      if (doService) begin
        irqVector <= vector;
      end
      // Pending flags wake the core regardless of any enable
      wakeUp    <= halted & |pending;
    end
  end

  // --------------------------------------------------------------
  // Return stack depth
  // --------------------------------------------------------------
  // The stack itself lives in the core; only its depth is kept here,
  // which is all that the full-stack hold needs
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stackPtr_r <= 4'h0;
    end else begin
      stackPtr_r <= stackPtr_nxt;
    end
  end

  // --------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------
  // One wait state: ack follows the taking edge and drops by itself,
  // so a master holding strobe high is answered again every second cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      if (rdStrobe) begin
        wb_dat_o <= readWord;
      end
    end
  end

endmodule
`default_nettype wire

/* File: five_source_interrupt_unit_chk.sv */
// Port-level assertions for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module five_source_interrupt_unit_chk #(
  parameter STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Bus and core strobes
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        slotStrobe,
  input wire logic        retPlain,
  input wire logic        retFromIrq,
  input wire logic        callPush,
  input wire logic        halted,
  // Service outputs
  input wire logic        irqTake,
  input wire logic        pushPc,
  input wire logic [10:0] irqVector,
  input wire logic        wakeUp,
  input wire logic [3:0]  stackPointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ack_once_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  take_slot_a: assert property (irqTake |-> $past(slotStrobe) && !$past(callPush))
    else $error("take outside a free slot");
  take_push_a: assert property (irqTake == pushPc)
    else $error("take and push differ");
  stack_bump_a: assert property (
    irqTake && !$past(retPlain || retFromIrq) |-> stackPointer == $past(stackPointer) + 4'h1)
    else $error("take did not push");
  full_hold_a: assert property (stackPointer == STACK_DEPTH |=> !irqTake)
    else $error("take with full stack");
  take_single_a: assert property (irqTake |=> !irqTake)
    else $error("second take without reenable");
  wake_cause_a: assert property (wakeUp |-> $past(halted))
    else $error("wake while running");
  vector_set_a: assert property (
    irqTake |-> irqVector[1:0] == 2'b00 && irqVector >= 11'h004 && irqVector <= 11'h014)
    else $error("vector out of table");
endmodule
bind five_source_interrupt_unit five_source_interrupt_unit_chk #(.STACK_DEPTH(STACK_DEPTH)) chk (
  .clock(clock), .reset_n(reset_n), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .slotStrobe(slotStrobe), .retPlain(retPlain), .retFromIrq(retFromIrq),
  .callPush(callPush), .halted(halted), .irqTake(irqTake), .pushPc(pushPc),
  .irqVector(irqVector), .wakeUp(wakeUp), .stackPointer(stackPointer));
`default_nettype wire

/* File: core_model.sv */
// Behavioural core sequencer: slots, returns, calls and halt
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Sequencer strobes
  output logic      slotStrobe,
  output logic      retPlain,
  output logic      retFromIrq,
  output logic      callPush,
  output logic      halted
);
  logic [1:0] slotCnt_r;
  initial begin
    retPlain = 1'b0;
    retFromIrq = 1'b0;
    callPush = 1'b0;
    halted = 1'b0;
  end
  // One slot in four, so a pending request waits a few cycles
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) slotCnt_r <= 2'h0;
    else slotCnt_r <= slotCnt_r + 2'h1;
  end
  assign slotStrobe = (slotCnt_r == 2'h3);
  // Return restores only the pc; routines save what they touch
  task pulse(input [1:0] kind);
    begin
      retPlain <= (kind == 2'h0);
      retFromIrq <= (kind == 2'h1);
      callPush <= (kind == 2'h2);
      @(posedge clock);
      retPlain <= 1'b0;
      retFromIrq <= 1'b0;
      callPush <= 1'b0;
      @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* File: five_source_interrupt_unit_bench.sv */
// Self-checking bench for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module five_source_interrupt_unit_bench;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [4:0]  src = 5'h00;
  wire  [31:0] rdat;
  wire  [10:0] irqVector;
  wire  [3:0]  stackPointer;
  wire         ack, slotStrobe, retPlain, retFromIrq, callPush, halted;
  wire         irqTake, wakeUp, stackFull, irq;
  integer      numErrors = 0;
  integer      cmpCount = 0;
  integer      takes = 0;
  integer      cycles = 0;
  integer      k;
  always #12.5 clock = ~clock;
  five_source_interrupt_unit uut (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmpAOut(!src[0]), .cmpBOut(!src[1]), .timerAOverflow(src[2]),
    .timerBOverflow(src[3]), .conversionDone(src[4]), .slotStrobe(slotStrobe),
    .retPlain(retPlain), .retFromIrq(retFromIrq), .callPush(callPush), .halted(halted),
    .irqTake(irqTake), .pushPc(), .irqVector(irqVector), .wakeUp(wakeUp),
    .stackPointer(stackPointer), .stackFull(stackFull), .irq(irq));
  core_model core (.clock(clock), .reset_n(reset_n), .slotStrobe(slotStrobe),
    .retPlain(retPlain), .retFromIrq(retFromIrq), .callPush(callPush), .halted(halted));
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmpCount = cmpCount + 1;
      if (g !== e) begin
        numErrors = numErrors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task endOfTest;
    begin
      $display("errors %0d comparisons %0d", numErrors, cmpCount);
      if (numErrors == 0 && cmpCount > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Takes are counted here so a pulse during a bus cycle is not missed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (irqTake === 1'b1) takes <= takes + 1;
    if (cycles == 5000) begin
      chk(32'h0, 32'h1);
      endOfTest;
    end
  end
  task bus(input [7:0] i, input w, input [7:0] d, output [31:0] q);
    begin
      cyc <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      q = rdat;
      cyc <= 1'b0;
      @(posedge clock);
    end
  endtask
  task wr(input [7:0] i, input [7:0] d);
    logic [31:0] q;
    bus(i, 1'b1, d, q);
  endtask
  task rd(input [7:0] i, input [7:0] e);
    logic [31:0] q;
    begin
      bus(i, 1'b0, 8'h00, q);
      chk(q, {24'h0, e});
    end
  endtask
  task waitTake(input integer n, input [31:0] e);
    begin
      while (takes != n) @(posedge clock);
      chk({21'h0, irqVector}, e);
    end
  endtask
  task pulse(input [4:0] s);
    begin
      src <= s;
      @(posedge clock);
      src <= 5'h00;
      @(posedge clock);
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(8'h0b, 8'h00);
    rd(8'h1e, 8'h00);
    wr(8'h0b, 8'h8e);
    rd(8'h0b, 8'h0e);
    wr(8'h1e, 8'hcf);
    rd(8'h1e, 8'h03);
    rd(8'h20, 8'h00);
    for (k = 0; k < 5; k = k + 1) begin
      pulse(5'h01 << k);
      repeat (6) @(posedge clock);
      rd(8'h0b, k < 3 ? 8'h10 << k | 8'h0e : 8'h0e);
      rd(8'h1e, k > 2 ? 8'h10 << (k - 3) | 8'h03 : 8'h03);
      wr(8'h0b, 8'h0e);
      wr(8'h1e, 8'h03);
    end
    chk(takes, 0);
    pulse(5'h1f);
    wr(8'h1e, 8'h33);
    wr(8'h0b, 8'h7f);
    waitTake(1, 32'h004);
    rd(8'h0b, 8'h6e);
    for (k = 1; k < 5; k = k + 1) begin
      if (k == 1) wr(8'h0b, 8'h6f);
      else core.pulse(2'h1);
      waitTake(k + 1, 4 * (k + 1));
    end
    chk(stackPointer, 2);
    repeat (2) core.pulse(2'h0);
    rd(8'h0b, 8'h0e);
    repeat (8) core.pulse(2'h2);
    chk(stackFull, 1);
    pulse(5'h04);
    wr(8'h0b, 8'h4f);
    repeat (16) @(posedge clock);
    chk(takes, 5);
    core.pulse(2'h0);
    waitTake(6, 32'h00c);
    core.halted <= 1'b1;
    pulse(5'h01);
    repeat (2) @(posedge clock);
    chk(wakeUp, 1);
    core.halted <= 1'b0;
    @(posedge clock);
    rd(8'h30, 8'h07);
    chk(irq, 0);
    wr(8'h31, 8'h02);
    chk(irq, 1);
    wr(8'h30, 8'h07);
    chk(irq, 0);
    rd(8'h30, 8'h00);
    endOfTest;
  end
endmodule
`default_nettype wire
